// [rtl/adcs_consts.svh]
// register offsets, field positions and reset values of the sequencer-zero config block
`ifndef ADCS_CONSTS_SVH
`define ADCS_CONSTS_SVH

`define ADCS_OFF_CONTROL      8'h00
`define ADCS_OFF_STATUS       8'h04
`define ADCS_OFF_IRQ_STATUS   8'h08
`define ADCS_OFF_IRQ_CLEAR    8'h0c
`define ADCS_OFF_IRQ_ENABLE   8'h10
`define ADCS_OFF_INPUT_SEL    8'h40
`define ADCS_OFF_SAMPLE_CTL   8'h44

`define ADCS_INPUT_SEL_RESET  32'h00000000
`define ADCS_SAMPLE_CTL_RESET 32'h00000000
`define ADCS_IRQ_ENABLE_RESET 2'h0
`define ADCS_INPUT_SEL_MASK   32'h33333333

`define ADCS_PICK_STRIDE      4
`define ADCS_FLAG_STRIDE      4
`define ADCS_FLAG_TEMP        3
`define ADCS_FLAG_IRQ         2
`define ADCS_FLAG_LAST        1
`define ADCS_FLAG_PAIR        0

`define ADCS_CTL_START_BIT    0
`define ADCS_EV_SAMPLE_IRQ    0
`define ADCS_EV_SEQ_DONE      1
`define ADCS_LAST_SLOT        3'h7

`endif

// [rtl/adcs_pkg.sv]
// types shared by the sequencer-zero config block
package adcs_pkg;
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ISSUE,
		SEQ_WAIT
	} adcs_seq_state_t;

	typedef logic [3:0] adcs_flags_t;
	typedef logic [1:0] adcs_events_t;
endpackage : adcs_pkg

// [rtl/adcs_avalon_slave.sv]
// avalon-mm slave front end with one wait state per access
`timescale 1ns/1ps
`default_nettype none

module adcs_avalon_slave (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [7:0]  avs_address,
	input  wire logic [31:0] rd_value,
	output var  logic        avs_waitrequest,
	output var  logic [31:0] avs_readdata,
	output var  logic        wr_strobe,
	output var  logic        rd_strobe
);
	logic        wait_reg;
	logic        wait_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;

	// a request is held one cycle with waitrequest high, then completes
	always_comb begin
		wait_next  = wait_reg;
		rdata_next = rdata_reg;
		if ((avs_read || avs_write) && wait_reg) begin
			wait_next = 1'b0;
			if (avs_read)
				rdata_next = rd_value;
		end else if (!wait_reg) begin
			wait_next = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			wait_reg  <= 1'b1;
			rdata_reg <= 32'h0;
		end else begin
			wait_reg  <= wait_next;
			rdata_reg <= rdata_next;
		end
	end

	assign avs_waitrequest = wait_reg;
	assign avs_readdata    = rdata_reg;
	assign wr_strobe       = avs_write && !wait_reg;
	assign rd_strobe       = avs_read && !wait_reg;
endmodule : adcs_avalon_slave

`default_nettype wire

// [rtl/adcs_irq_block.sv]
// sticky event status, enable mask and level interrupt output
`timescale 1ns/1ps
`default_nettype none
`include "adcs_consts.svh"

module adcs_irq_block (
	input  wire logic       mclk,
	input  wire logic       srst,
	input  wire logic [1:0] event_set,
	input  wire logic [1:0] clear_bits,
	input  wire logic       clear_write,
	input  wire logic [1:0] enable_bits,
	input  wire logic       enable_write,
	output var  logic [1:0] status,
	output var  logic [1:0] enable,
	output var  logic       irq
);
	logic [1:0] status_reg;
	logic [1:0] status_next;
	logic [1:0] enable_reg;
	logic [1:0] enable_next;
	logic       irq_reg;
	logic       irq_next;

	// a new event in the clearing cycle is kept
	always_comb begin
		status_next = status_reg;
		if (clear_write)
			status_next = status_next & ~clear_bits;
		status_next = status_next | event_set;
		enable_next = enable_write ? enable_bits : enable_reg;
		irq_next    = |(status_next & enable_next);
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			status_reg <= 2'h0;
			enable_reg <= `ADCS_IRQ_ENABLE_RESET;
			irq_reg    <= 1'b0;
		end else begin
			status_reg <= status_next;
			enable_reg <= enable_next;
			irq_reg    <= irq_next;
		end
	end

	assign status = status_reg;
	assign enable = enable_reg;
	assign irq    = irq_reg;
endmodule : adcs_irq_block

`default_nettype wire

// [rtl/adcs_seq0_config.sv]
// sequencer-zero per-slot configuration registers and slot stepping logic
//
// How it works
// [R01] slot 8 input pick at bits 29:28
// [R02] field value is the analog input number
// [R03] slots 1-7 picks at 1:0 .. 25:24
// [R04] reserved gaps read zero, software preserves them
// [R05] software sets a last-sample flag somewhere
// [R06] 4-bit flag group per slot, reset zero
// [R07] temp flag converts temperature sensor instead
// [R08] irq flag raises raw irq after conversion
// [R09] nothing requested after the last-sample slot
// [R10] pair flag samples inputs 2i and 2i+1
// [R11] slots run ascending from slot 1 per trigger
`timescale 1ns/1ps
`default_nettype none
`include "adcs_consts.svh"

module adcs_seq0_config (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [7:0]  avs_address,
	input  wire logic [31:0] avs_writedata,
	output var  logic        avs_waitrequest,
	output var  logic [31:0] avs_readdata,
	input  wire logic        seq_start,
	input  wire logic        conv_done,
	output var  logic        conv_req,
	output var  logic [1:0]  conv_input,
	output var  logic        conv_temp,
	output var  logic        conv_pair,
	output var  logic        seq0_raw_irq,
	output var  logic        seq_busy,
	output var  logic        irq
);

	////////////////////////////////////////////////////////////////////////////////
	// field helpers

	function automatic logic [1:0] slot_pick(input logic [31:0] sel, input logic [2:0] slot);
		slot_pick = sel[slot*`ADCS_PICK_STRIDE +: 2];
	endfunction : slot_pick

	function automatic adcs_pkg::adcs_flags_t slot_flags(input logic [31:0] ctl,
			input logic [2:0] slot);
		slot_flags = ctl[slot*`ADCS_FLAG_STRIDE +: 4];
	endfunction : slot_flags

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	logic                       wr_strobe;
	logic                       rd_strobe;
	logic [31:0]                rd_value;
	logic [1:0]                 irq_status;
	logic [1:0]                 irq_enable;
	logic                       irq_int;
	adcs_pkg::adcs_events_t     event_set;
	logic                       clear_write;
	logic                       enable_write;
	logic                       sw_start;

	logic [31:0]                seq0_input_select_reg;
	logic [31:0]                seq0_input_select_next;
	logic [31:0]                seq0_sample_control_reg;
	logic [31:0]                seq0_sample_control_next;

	adcs_pkg::adcs_seq_state_t  state_reg;
	adcs_pkg::adcs_seq_state_t  state_next;
	logic [2:0]                 slot_reg;
	logic [2:0]                 slot_next;
	logic                       conv_req_reg;
	logic                       conv_req_next;
	logic [1:0]                 conv_input_reg;
	logic [1:0]                 conv_input_next;
	logic                       conv_temp_reg;
	logic                       conv_temp_next;
	logic                       conv_pair_reg;
	logic                       conv_pair_next;
	logic                       raw_irq_reg;
	logic                       raw_irq_next;
	logic                       done_ev_reg;
	logic                       done_ev_next;
	logic                       busy_reg;
	logic                       busy_next;

	logic [1:0]                 cur_pick;
	adcs_pkg::adcs_flags_t      cur_flags;

	////////////////////////////////////////////////////////////////////////////////
	// bus front end and interrupt block

	adcs_avalon_slave u_bus (
		.mclk            (mclk),
		.srst            (srst),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_address     (avs_address),
		.rd_value        (rd_value),
		.avs_waitrequest (avs_waitrequest),
		.avs_readdata    (avs_readdata),
		.wr_strobe       (wr_strobe),
		.rd_strobe       (rd_strobe)
	);

	adcs_irq_block u_irq (
		.mclk         (mclk),
		.srst         (srst),
		.event_set    (event_set),
		.clear_bits   (avs_writedata[1:0]),
		.clear_write  (clear_write),
		.enable_bits  (avs_writedata[1:0]),
		.enable_write (enable_write),
		.status       (irq_status),
		.enable       (irq_enable),
		.irq          (irq_int)
	);

	assign clear_write  = wr_strobe && (avs_address == `ADCS_OFF_IRQ_CLEAR);
	assign enable_write = wr_strobe && (avs_address == `ADCS_OFF_IRQ_ENABLE);
	assign sw_start     = wr_strobe && (avs_address == `ADCS_OFF_CONTROL)
		&& avs_writedata[`ADCS_CTL_START_BIT];

	always_comb begin
		event_set                      = 2'h0;
		event_set[`ADCS_EV_SAMPLE_IRQ] = raw_irq_reg;
		event_set[`ADCS_EV_SEQ_DONE]   = done_ev_reg;
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		rd_value = 32'h0;
		unique case (avs_address)
			`ADCS_OFF_STATUS:     rd_value = {27'h0, slot_reg, 1'b0, busy_reg};
			`ADCS_OFF_IRQ_STATUS: rd_value = {30'h0, irq_status};
			`ADCS_OFF_IRQ_ENABLE: rd_value = {30'h0, irq_enable};
			`ADCS_OFF_INPUT_SEL:  rd_value = seq0_input_select_reg;
			`ADCS_OFF_SAMPLE_CTL: rd_value = seq0_sample_control_reg;
			default:              rd_value = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_comb begin
		seq0_input_select_next   = seq0_input_select_reg;
		seq0_sample_control_next = seq0_sample_control_reg;
		if (wr_strobe && avs_address == `ADCS_OFF_INPUT_SEL)
			seq0_input_select_next = avs_writedata & `ADCS_INPUT_SEL_MASK; // R04
		if (wr_strobe && avs_address == `ADCS_OFF_SAMPLE_CTL)
			seq0_sample_control_next = avs_writedata; // R06
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			seq0_input_select_reg   <= `ADCS_INPUT_SEL_RESET; // R04
			seq0_sample_control_reg <= `ADCS_SAMPLE_CTL_RESET; // R06
		end else begin
			seq0_input_select_reg   <= seq0_input_select_next;
			seq0_sample_control_reg <= seq0_sample_control_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// slot sequencer

	assign cur_pick  = slot_pick(seq0_input_select_reg, slot_reg); // R01 R03
	assign cur_flags = slot_flags(seq0_sample_control_reg, slot_reg); // R06

	always_comb begin
		state_next      = state_reg;
		slot_next       = slot_reg;
		conv_req_next   = 1'b0;
		conv_input_next = conv_input_reg;
		conv_temp_next  = conv_temp_reg;
		conv_pair_next  = conv_pair_reg;
		raw_irq_next    = 1'b0;
		done_ev_next    = 1'b0;
		busy_next       = busy_reg;
		unique case (state_reg)
			adcs_pkg::SEQ_IDLE: begin
				if (seq_start || sw_start) begin
					slot_next  = 3'h0; // R11
					busy_next  = 1'b1;
					state_next = adcs_pkg::SEQ_ISSUE;
				end
			end
			adcs_pkg::SEQ_ISSUE: begin
				// input, temp and pair settings are latched here; the irq and last flags are read live from the register at conv_done
				conv_req_next   = 1'b1;
				conv_input_next = cur_pick; // R02
				conv_temp_next  = cur_flags[`ADCS_FLAG_TEMP]; // R07
				conv_pair_next  = cur_flags[`ADCS_FLAG_PAIR]
					&& !cur_flags[`ADCS_FLAG_TEMP]; // R10
				state_next      = adcs_pkg::SEQ_WAIT;
			end
			adcs_pkg::SEQ_WAIT: begin
				if (conv_done) begin
					raw_irq_next = cur_flags[`ADCS_FLAG_IRQ]; // R08
					// a missing last flag still stops after slot 8
					if (cur_flags[`ADCS_FLAG_LAST] || slot_reg == `ADCS_LAST_SLOT) begin
						state_next   = adcs_pkg::SEQ_IDLE; // R09 R05
						busy_next    = 1'b0;
						done_ev_next = 1'b1;
					end else begin
						slot_next  = slot_reg + 3'h1; // R11
						state_next = adcs_pkg::SEQ_ISSUE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg      <= adcs_pkg::SEQ_IDLE;
			slot_reg       <= 3'h0;
			conv_req_reg   <= 1'b0;
			conv_input_reg <= 2'h0;
			conv_temp_reg  <= 1'b0;
			conv_pair_reg  <= 1'b0;
			raw_irq_reg    <= 1'b0;
			done_ev_reg    <= 1'b0;
			busy_reg       <= 1'b0;
		end else begin
			state_reg      <= state_next;
			slot_reg       <= slot_next;
			conv_req_reg   <= conv_req_next;
			conv_input_reg <= conv_input_next;
			conv_temp_reg  <= conv_temp_next;
			conv_pair_reg  <= conv_pair_next;
			raw_irq_reg    <= raw_irq_next;
			done_ev_reg    <= done_ev_next;
			busy_reg       <= busy_next;
		end
	end

	assign conv_req     = conv_req_reg;
	assign conv_input   = conv_input_reg;
	assign conv_temp    = conv_temp_reg;
	assign conv_pair    = conv_pair_reg;
	assign seq0_raw_irq = raw_irq_reg;
	assign seq_busy     = busy_reg;
	assign irq          = irq_int;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	property p_r01;
		@(posedge mclk) disable iff (srst)
		(conv_req_reg && slot_reg == 3'h7)
			|-> conv_input_reg == $past(seq0_input_select_reg[29:28]);
	endproperty
	a_r01: assert property (p_r01) else $error("slot 8 input pick mismatch"); // R01

	property p_r02;
		@(posedge mclk) disable iff (srst)
		$rose(conv_req_reg) |-> conv_input_reg == $past(cur_pick);
	endproperty
	a_r02: assert property (p_r02) else $error("input number not taken from field"); // R02

	property p_r03;
		@(posedge mclk) disable iff (srst)
		(conv_req_reg && slot_reg == 3'h0)
			|-> conv_input_reg == $past(seq0_input_select_reg[1:0]);
	endproperty
	a_r03: assert property (p_r03) else $error("slot 1 input pick mismatch"); // R03

	property p_r04;
		@(posedge mclk) disable iff (srst)
		(seq0_input_select_reg & ~`ADCS_INPUT_SEL_MASK) == 32'h0;
	endproperty
	a_r04: assert property (p_r04) else $error("reserved select bits not zero"); // R04

	property p_r06;
		@(posedge mclk)
		$fell(srst) |-> seq0_sample_control_reg == 32'h0 && seq0_input_select_reg == 32'h0;
	endproperty
	a_r06: assert property (p_r06) else $error("config registers not zero after reset"); // R06

	property p_r07;
		@(posedge mclk) disable iff (srst)
		conv_req_reg |-> conv_temp_reg == $past(cur_flags[3]);
	endproperty
	a_r07: assert property (p_r07) else $error("temperature select not applied"); // R07

	property p_r08;
		@(posedge mclk) disable iff (srst)
		(state_reg == adcs_pkg::SEQ_WAIT && conv_done && cur_flags[2])
			|=> seq0_raw_irq ##1 !seq0_raw_irq;
	endproperty
	a_r08: assert property (p_r08) else $error("raw irq not pulsed after slot"); // R08

	property p_r09;
		@(posedge mclk) disable iff (srst)
		(state_reg == adcs_pkg::SEQ_WAIT && conv_done && cur_flags[1])
			|=> state_reg == adcs_pkg::SEQ_IDLE && !busy_reg ##1 !conv_req_reg;
	endproperty
	a_r09: assert property (p_r09) else $error("conversion requested after last slot"); // R09

	property p_r10;
		@(posedge mclk) disable iff (srst)
		conv_req_reg |-> !(conv_pair_reg && conv_temp_reg)
			&& conv_pair_reg == ($past(cur_flags[0]) && !$past(cur_flags[3]));
	endproperty
	a_r10: assert property (p_r10) else $error("pair sampling flag wrong"); // R10

	property p_r11;
		@(posedge mclk) disable iff (srst)
		(state_reg == adcs_pkg::SEQ_IDLE && seq_start)
			|=> slot_reg == 3'h0 ##1 conv_req_reg && slot_reg == 3'h0;
	endproperty
	a_r11: assert property (p_r11) else $error("sequence did not start at slot 1"); // R11

endmodule : adcs_seq0_config

`default_nettype wire

// [bench/adcs_conv_model.sv]
// converter core model that finishes each requested conversion after a short or long delay
`timescale 1ns/1ps
`default_nettype none

module adcs_conv_model (
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic slow,
	input  wire logic conv_req,
	output var  logic conv_done
);
	logic [3:0] wait_reg;
	logic       busy_reg;

	// one done pulse per request, never one without a request pending
	always_ff @(posedge mclk) begin
		conv_done <= 1'b0;
		if (srst) begin
			busy_reg <= 1'b0;
			wait_reg <= 4'h0;
		end else if (conv_req) begin
			busy_reg <= 1'b1;
			wait_reg <= slow ? 4'h6 : 4'h0;
		end else if (busy_reg) begin
			if (wait_reg == 4'h0) begin
				conv_done <= 1'b1;
				busy_reg  <= 1'b0;
			end else begin
				wait_reg <= wait_reg - 4'h1;
			end
		end
	end
endmodule : adcs_conv_model

`default_nettype wire

// [bench/tb.sv]
// self-checking bench: registers over avalon, sequences against the converter model
`timescale 1ns/1ps
`default_nettype none
`include "adcs_consts.svh"

module tb;
	logic        mclk, srst, avs_read, avs_write, avs_waitrequest;
	logic [7:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd, isel, ctl;
	logic        seq_start, conv_done, conv_req, conv_temp, conv_pair;
	logic        seq0_raw_irq, seq_busy, irq, slow;
	logic [1:0]  conv_input;
	logic [3:0]  got_q[$];
	int          n_errors, n_checks, n_raw, cyc;

	adcs_seq0_config DUT (.mclk(mclk), .srst(srst), .avs_read(avs_read),
		.avs_write(avs_write), .avs_address(avs_address), .avs_writedata(avs_writedata),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.seq_start(seq_start), .conv_done(conv_done), .conv_req(conv_req),
		.conv_input(conv_input), .conv_temp(conv_temp), .conv_pair(conv_pair),
		.seq0_raw_irq(seq0_raw_irq), .seq_busy(seq_busy), .irq(irq));
	adcs_conv_model core (.mclk(mclk), .srst(srst), .slow(slow), .conv_req(conv_req),
		.conv_done(conv_done));

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// request held until waitrequest is sampled low, released at that same edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= ~wr;
		avs_write     <= wr;
		@(posedge mclk);
		while (avs_waitrequest !== 1'b0)
			@(posedge mclk);
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge mclk);
	endtask : bus

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask : rd_chk

	function automatic logic [3:0] slot_exp(input int n);
		logic t;
		t = ctl[4*n+3];
		return {isel[4*n+:2], t, ctl[4*n] & ~t};
	endfunction : slot_exp

	////////////////////////////////////////////////////////////////////////////////
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (conv_req === 1'b1)
			got_q.push_back({conv_input, conv_temp, conv_pair});
		if (seq0_raw_irq === 1'b1)
			n_raw++;
		if (cyc == 30000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic run_seq(input int last, input logic via_reg);
		int          exp_raw;
		logic [3:0]  e;
		logic [3:0]  g;
		isel = $urandom & `ADCS_INPUT_SEL_MASK;
		ctl  = $urandom & 32'hdddddddd;
		ctl[4*(last-1)+1] = 1'b1;
		slow <= via_reg;
		bus(1'b1, `ADCS_OFF_INPUT_SEL, isel);
		bus(1'b1, `ADCS_OFF_SAMPLE_CTL, ctl);
		bus(1'b1, `ADCS_OFF_IRQ_CLEAR, 32'h3);
		got_q.delete();
		n_raw = 0;
		exp_raw = 0;
		if (via_reg)
			bus(1'b1, `ADCS_OFF_CONTROL, 32'h1);
		else begin
			seq_start <= 1'b1;
			@(posedge mclk);
			seq_start <= 1'b0;
		end
		repeat (3) @(posedge mclk);
		seq_start <= 1'b1; // ignored while busy
		@(posedge mclk);
		seq_start <= 1'b0;
		while (seq_busy !== 1'b0)
			@(posedge mclk);
		repeat (4) @(posedge mclk);
		check("slot count", got_q.size(), last);
		for (int n = 0; n < last && n < got_q.size(); n++) begin
			e = slot_exp(n);
			g = got_q[n];
			exp_raw += ctl[4*n+2];
			check("temp pick", g[1], e[1]);
			check("pair pick", g[0], e[0]);
			if (e[1] == 1'b0)
				check("input pick", g[3:2], e[3:2]);
		end
		check("raw irq count", n_raw, exp_raw);
		rd_chk("seq status", `ADCS_OFF_STATUS, (last - 1) << 2);
		rd_chk("irq status", `ADCS_OFF_IRQ_STATUS, {30'h0, 1'b1, exp_raw != 0});
		bus(1'b1, `ADCS_OFF_IRQ_ENABLE, 32'h2);
		check("irq on", irq, 1'b1);
		bus(1'b1, `ADCS_OFF_IRQ_CLEAR, 32'h2);
		check("irq off", irq, 1'b0);
		bus(1'b1, `ADCS_OFF_IRQ_ENABLE, 32'h0);
		$display("test sequence last slot %0d done", last);
	endtask : run_seq

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		srst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		seq_start = 1'b0;
		slow = 1'b0;
		n_errors = 0;
		n_checks = 0;
		n_raw = 0;
		cyc = 0;
		void'($urandom(19));
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		rd_chk("input_select reset", `ADCS_OFF_INPUT_SEL, `ADCS_INPUT_SEL_RESET);
		rd_chk("sample_control reset", `ADCS_OFF_SAMPLE_CTL, `ADCS_SAMPLE_CTL_RESET);
		rd_chk("irq enable reset", `ADCS_OFF_IRQ_ENABLE, 32'h0);
		rd_chk("unmapped", 8'h80, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			isel = (i == 0) ? `ADCS_INPUT_SEL_MASK : $urandom & `ADCS_INPUT_SEL_MASK;
			ctl  = (i == 0) ? 32'hffffffff : $urandom;
			bus(1'b1, `ADCS_OFF_INPUT_SEL, isel);
			rd_chk("input_select", `ADCS_OFF_INPUT_SEL, isel & 32'h33333333);
			bus(1'b1, `ADCS_OFF_SAMPLE_CTL, ctl);
			rd_chk("sample_control", `ADCS_OFF_SAMPLE_CTL, ctl);
		end
		bus(1'b1, `ADCS_OFF_INPUT_SEL, 32'h10000000);
		rd_chk("slot8 pick", `ADCS_OFF_INPUT_SEL, 32'h10000000);
		bus(1'b1, `ADCS_OFF_IRQ_STATUS, 32'h3);
		rd_chk("status read only", `ADCS_OFF_IRQ_STATUS, 32'h0);
		bus(1'b1, 8'h80, 32'hffffffff);
		rd_chk("unmapped after write", 8'h80, 32'h0);
		$display("test registers done");
		run_seq(1, 1'b0);
		run_seq(8, 1'b1);
		for (int i = 0; i < 6; i++)
			run_seq(1 + ($urandom % 8), i[0]);
		stop_test();
	end
endmodule : tb

`default_nettype wire
